/* core/two_wire_bus_master_cfg.svh */
// Purpose: Constants for the two-wire master interrupt enable block
// Assumes: Byte addresses on the register port, 32-bit data
// Notes:   Included by the package and the design modules
`ifndef TMIE_CFG_SVH
`define TMIE_CFG_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define TMIE_ADDR_W        12
`define TMIE_OFS_ENABLE    12'h300
`define TMIE_OFS_SET       12'h304
`define TMIE_OFS_CLEAR     12'h308

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TMIE_BIT_HALTED    1
`define TMIE_BIT_ERROR     9
`define TMIE_BIT_PAUSED    18
`define TMIE_BIT_RX_BEGUN  19
`define TMIE_BIT_TX_BEGUN  20
`define TMIE_BIT_LAST_RX   23
`define TMIE_BIT_LAST_TX   24
`define TMIE_ENABLE_RESET  32'h0000_0000
`define TMIE_EN_RESET      1'b0
`define TMIE_RDATA_IDLE    32'h0000_0000
`define TMIE_NUM_EVENTS    7

`endif

/* core/two_wire_bus_master_pkg.sv */
// Purpose: Types for the two-wire master interrupt enable block
// Assumes: two_wire_bus_master_cfg.svh holds the numbers
// Notes:   Carrier struct for the register port, operation enum for the gates
`include "two_wire_bus_master_cfg.svh"
package tmie_pkg;
  typedef struct packed {
    logic [`TMIE_ADDR_W-1:0] addr;
    logic [31:0]             wdata;
    logic                    wr;
    logic                    rd;
  } tmie_req_s;

  typedef enum logic [1:0] {
    TMIE_OP_NONE  = 2'b00,
    TMIE_OP_WRITE = 2'b01,
    TMIE_OP_SET   = 2'b10,
    TMIE_OP_CLEAR = 2'b11
  } tmie_op_e;
endpackage

/* core/two_wire_bus_master_gate.sv */
// Purpose: One enable bit and its event gate
// Assumes: Operation decoded by the parent
// Notes:   Event pulse gated by the stored enable
`timescale 1ns/1ps
`include "two_wire_bus_master_cfg.svh"
module tmie_gate (
  input  wire logic               clk_sys_i,
  input  wire logic               resetn_i,
  input  wire tmie_pkg::tmie_op_e op_i,
  input  wire logic               wbit_i,
  input  wire logic               event_i,
  output logic                    enable_o,
  output logic                    fire_o
);
  import tmie_pkg::*;

  // ----------------------------------------------------------------
  // Enable state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      enable_o <= `TMIE_EN_RESET;
    end else begin
      case (op_i)
        TMIE_OP_WRITE: enable_o <= wbit_i;
        TMIE_OP_SET:   if (wbit_i) enable_o <= 1'b1;
        TMIE_OP_CLEAR: if (wbit_i) enable_o <= 1'b0;
        default:       enable_o <= enable_o;
      endcase
    end
  end

  assign fire_o = event_i & enable_o;
endmodule

/* core/two_wire_bus_master_irq_enable.sv */
// Purpose: Interrupt enable, set and clear registers with irq output
// Assumes: Events are one-cycle pulses from the protocol engine
// Notes:   Three addresses view one shared enable state
`timescale 1ns/1ps
`include "two_wire_bus_master_cfg.svh"
module tmie_irq_enable (
  input  wire logic                        clk_sys_i,
  input  wire logic                        resetn_i,
  input  wire tmie_pkg::tmie_req_s         req_i,
  input  wire logic [`TMIE_NUM_EVENTS-1:0] event_i,
  output logic [31:0]                      rdata_o,
  output logic                             irq_o
);
  import tmie_pkg::*;

  // ----------------------------------------------------------------
  // Event order: halted, error, paused, rx begun, tx begun, last rx, last tx
  // ----------------------------------------------------------------
  // Positions are sparse; every other bit is ignored and reads zero
  localparam int NUM_EV = `TMIE_NUM_EVENTS;
  localparam int POS [NUM_EV] = '{
    `TMIE_BIT_HALTED,
    `TMIE_BIT_ERROR,
    `TMIE_BIT_PAUSED,
    `TMIE_BIT_RX_BEGUN,
    `TMIE_BIT_TX_BEGUN,
    `TMIE_BIT_LAST_RX,
    `TMIE_BIT_LAST_TX
  };

  tmie_op_e          op;
  logic [NUM_EV-1:0] en;
  logic [NUM_EV-1:0] fire;
  logic [31:0]       en_word;
  logic              hit_map;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Only writes act on state; a read never moves an enable
  always_comb begin
    op = TMIE_OP_NONE;
    if (req_i.wr) begin
      case (req_i.addr)
        `TMIE_OFS_ENABLE: op = TMIE_OP_WRITE;
        `TMIE_OFS_SET:    op = TMIE_OP_SET;
        `TMIE_OFS_CLEAR:  op = TMIE_OP_CLEAR;
        default:          op = TMIE_OP_NONE;
      endcase
    end
  end

  // Any of the three views; other offsets read as zero
  always_comb begin
    hit_map = 1'b0;
    case (req_i.addr)
      `TMIE_OFS_ENABLE: hit_map = 1'b1;
      `TMIE_OFS_SET:    hit_map = 1'b1;
      `TMIE_OFS_CLEAR:  hit_map = 1'b1;
      default:          hit_map = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Per-event enable bits
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_EV; g++) begin : g_bit
      // Covers each enable
      tmie_gate u_gate (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .op_i      (op),
        .wbit_i    (req_i.wdata[POS[g]]),
        .event_i   (event_i[g]),
        .enable_o  (en[g]),
        .fire_o    (fire[g])
      );
    end
  endgenerate

  // Scatter the compact enables to their register positions
  always_comb begin
    en_word = `TMIE_ENABLE_RESET;
    for (int i = 0; i < NUM_EV; i++) begin
      en_word[POS[i]] = en[i];
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Data stands for one cycle only, so a late sample sees zero
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rdata_o <= `TMIE_RDATA_IDLE;
    end else if (req_i.rd && hit_map) begin
      rdata_o <= en_word;
    end else begin
      rdata_o <= `TMIE_RDATA_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  // Registered so the output comes from a flop; costs one cycle
  // Not sticky: the event source holds its flag to keep irq up
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |fire;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  irq_follows_a: assert property (irq_o == $past(|(event_i & en)))
    else $error("irq does not follow enabled events");

  set_enables_a: assert property (
    req_i.wr && req_i.addr == `TMIE_OFS_SET && req_i.wdata[`TMIE_BIT_HALTED]
    |=> en[0]) else $error("set write did not enable");

  set_zero_keeps_a: assert property (
    req_i.wr && req_i.addr == `TMIE_OFS_SET && !req_i.wdata[`TMIE_BIT_ERROR]
    |=> en[1] == $past(en[1])) else $error("set zero changed enable");

  clear_disables_a: assert property (
    req_i.wr && req_i.addr == `TMIE_OFS_CLEAR && req_i.wdata[`TMIE_BIT_PAUSED]
    |=> !en[2]) else $error("clear write did not disable");

  write_stores_a: assert property (
    req_i.wr && req_i.addr == `TMIE_OFS_ENABLE
    |=> en[3] == $past(req_i.wdata[`TMIE_BIT_RX_BEGUN]))
    else $error("enable write not stored");

  read_enable_a: assert property (
    req_i.rd && req_i.addr == `TMIE_OFS_SET |=> rdata_o == $past(en_word))
    else $error("set read mismatch");

  read_mirror_a: assert property (
    req_i.rd && req_i.addr == `TMIE_OFS_CLEAR
    |=> rdata_o[`TMIE_BIT_LAST_TX] == $past(en[6]))
    else $error("clear read mismatch");

  idle_hold_a: assert property (
    !req_i.wr |=> en == $past(en)) else $error("enable changed without write");

  // ----------------------------------------------------------------
  // Read, unmapped write and interrupt checks
  // ----------------------------------------------------------------
  read_idle_a: assert property (
    !req_i.rd |=> rdata_o == `TMIE_RDATA_IDLE) else $error("read data outside a read");

  read_unmapped_a: assert property (
    req_i.rd && !hit_map |=> rdata_o == `TMIE_RDATA_IDLE)
    else $error("unmapped read not zero");

  read_word_a: assert property (
    req_i.rd && req_i.addr == `TMIE_OFS_ENABLE |=> rdata_o == $past(en_word))
    else $error("enable read mismatch");

  unmapped_write_a: assert property (
    req_i.wr && !hit_map |=> en == $past(en))
    else $error("unmapped write changed enable");

  irq_quiet_a: assert property (
    event_i == '0 |=> !irq_o) else $error("irq without event");

  irq_blocked_a: assert property (
    en == '0 |=> !irq_o) else $error("irq while all disabled");

  // ----------------------------------------------------------------
  // Per-bit checks
  // ----------------------------------------------------------------
  // One set of checks per event, so every position is exercised
  generate
    for (g = 0; g < NUM_EV; g++) begin : g_chk
      bit_set_a: assert property (
        req_i.wr && req_i.addr == `TMIE_OFS_SET && req_i.wdata[POS[g]]
        |=> en[g]) else $error("set write did not enable a bit");

      bit_clear_a: assert property (
        req_i.wr && req_i.addr == `TMIE_OFS_CLEAR && req_i.wdata[POS[g]]
        |=> !en[g]) else $error("clear write did not disable a bit");

      bit_write_a: assert property (
        req_i.wr && req_i.addr == `TMIE_OFS_ENABLE
        |=> en[g] == $past(req_i.wdata[POS[g]]))
        else $error("enable write not stored in a bit");

      bit_keep_a: assert property (
        req_i.wr && req_i.addr == `TMIE_OFS_SET && !req_i.wdata[POS[g]]
        |=> en[g] == $past(en[g])) else $error("set zero changed a bit");

      bit_irq_a: assert property (
        event_i[g] && en[g] |=> irq_o)
        else $error("enabled event gave no irq");

      bit_read_a: assert property (
        req_i.rd && hit_map
        |=> rdata_o[POS[g]] == $past(en[g]))
        else $error("read bit differs from enable");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  // Main scenarios: irq, set, clear, plain write, mapped read
  irq_cov_c:   cover property (irq_o);
  set_cov_c:   cover property (op == TMIE_OP_SET ##1 en != '0);
  clear_cov_c: cover property (op == TMIE_OP_CLEAR ##1 en == '0);
  write_cov_c: cover property (op == TMIE_OP_WRITE ##1 en == '1);
  read_cov_c:  cover property (req_i.rd && hit_map ##1 rdata_o != '0);
endmodule

/* tb/two_wire_bus_master_irq_enable_tb.sv */
// Purpose: Self-checking bench for the interrupt enable block
// Assumes: Register port with one-cycle read latency
// Notes:   Design files carry their own assertions
`timescale 1ns/1ps
`include "two_wire_bus_master_cfg.svh"
module twowire_master_irq_enable_tb;
  import tmie_pkg::*;
  localparam logic [31:0] ALL = 32'h019c_0202;
  localparam int          POS [`TMIE_NUM_EVENTS] = '{`TMIE_BIT_HALTED, `TMIE_BIT_ERROR,
    `TMIE_BIT_PAUSED, `TMIE_BIT_RX_BEGUN, `TMIE_BIT_TX_BEGUN, `TMIE_BIT_LAST_RX,
    `TMIE_BIT_LAST_TX};
  logic        clk_sys_i;
  logic        resetn_i;
  tmie_req_s   req;
  logic [6:0]  event_i;
  logic [31:0] rdata_o;
  logic        irq_o;
  int          miscompares;
  int          check_count;

  tmie_irq_enable DUT (
    .clk_sys_i(clk_sys_i),
    .resetn_i (resetn_i),
    .req_i    (req),
    .event_i  (event_i),
    .rdata_o  (rdata_o),
    .irq_o    (irq_o)
  );

  // ----------------------------------------
  // Clock, access tasks and checks
  // ----------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge clk_sys_i);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clk_sys_i);
    req.wr    <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rd(logic [11:0] a, logic [31:0] exp);
    @(posedge clk_sys_i);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk_sys_i);
    req.rd   <= 1'b0;
    #1 check("rdata", rdata_o, exp);
  endtask

  // Irq is per cycle, so it must drop again
  task automatic pulse(int i, logic exp);
    @(posedge clk_sys_i);
    event_i <= 7'h01 << i;
    @(posedge clk_sys_i);
    event_i <= 7'h00;
    #1 check("irq", {31'h0, irq_o}, {31'h0, exp});
    @(posedge clk_sys_i);
    #1 check("irq idle", {31'h0, irq_o}, 32'h0);
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (3000) @(posedge clk_sys_i);
    miscompares++;
    report_and_stop();
  end

  initial begin
    miscompares = 0;
    check_count = 0;
    resetn_i    = 1'b0;
    req         = '0;
    event_i     = 7'h00;
    repeat (20) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    rd(`TMIE_OFS_ENABLE, 32'h0);
    rd(`TMIE_OFS_SET, 32'h0);
    rd(`TMIE_OFS_CLEAR, 32'h0);
    $display("Test reset done");
    wr(`TMIE_OFS_ENABLE, 32'hffff_ffff);
    rd(`TMIE_OFS_ENABLE, ALL);
    wr(`TMIE_OFS_CLEAR, 32'h0000_0202);
    rd(`TMIE_OFS_SET, ALL & ~32'h202);
    wr(`TMIE_OFS_SET, 32'h0);
    rd(`TMIE_OFS_CLEAR, ALL & ~32'h202);
    wr(12'h30c, 32'hffff_ffff);
    rd(12'h30c, 32'h0);
    rd(`TMIE_OFS_ENABLE, ALL & ~32'h202);
    $display("Test register views done");
    wr(`TMIE_OFS_ENABLE, 32'h0);
    for (int i = 0; i < `TMIE_NUM_EVENTS; i++) begin
      pulse(i, 1'b0);
      wr(`TMIE_OFS_SET, 32'h1 << POS[i]);
      rd(`TMIE_OFS_ENABLE, 32'h1 << POS[i]);
      pulse(i, 1'b1);
      pulse((i + 1) % `TMIE_NUM_EVENTS, 1'b0);
      wr(`TMIE_OFS_CLEAR, 32'h1 << POS[i]);
    end
    $display("Test event gating done");
    wr(`TMIE_OFS_ENABLE, 32'hffff_ffff);
    rd(`TMIE_OFS_CLEAR, ALL);
    @(posedge clk_sys_i);
    resetn_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    rd(`TMIE_OFS_SET, 32'h0);
    pulse(0, 1'b0);
    $display("Test mid-run reset done");
    report_and_stop();
  end
endmodule
